// *** core/qip_irq_pin_ctrl.sv ***
// Interrupt, chip select D and ready pin control of a quad UART
// Behaviour
// R1 - Mode pin high strobe bus, low rw-line
// R2 - Strobe mode: chip select D selects D
// R3 - Rw-line mode ignores chip select D
// R4 - Strobe mode: enable bit drives channel A
// R5 - Enable bit zero floats A; resets zero
// R6 - Channels B-D follow own enable bit
// R7 - Rw-line mode: A is open-drain device IRQ
// R8 - Rw-line mode: B-D held driven low
// R9 - Force-enable high drives all outputs; in rw-line mode A still drives only while the device IRQ is pending
// R10 - Force-enable low: enable bits decide
// R11 - Force-enable active high, pulled down
// R12 - System holds force-enable low in rw-line
// R13 - Variant without pin acts forced high
// R14 - Per-channel active-low transmit ready output
// R15 - Per-channel active-low receive ready output
module qip_irq_pin_ctrl
   import qip_pkg::*;
#(
   parameter bit HAS_FORCE_PIN = 1'b1
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Pins from outside
   input  wire logic                busModeSel,
   input  wire logic                chan_d_select_n,
   input  wire logic                irq_force_enable,
   // UART core side, same clock
   input  wire logic [NUM_CHAN-1:0] chanIrq,
   input  wire logic [NUM_CHAN-1:0] oeBitWrite,
   input  wire logic [NUM_CHAN-1:0] oeBitValue,
   input  wire qip_stat_t           fifoStat,
   // Status back to the core
   output logic [NUM_CHAN-1:0]      irq_output_enable_bit,
   output logic                     strobeMode,
   output logic                     chanDSelected,
   // Interrupt pins
   output qip_pin_grp_t             irqPins,
   // Ready pins
   output logic [NUM_CHAN-1:0]      tx_ready_n_per_chan,
   output logic [NUM_CHAN-1:0]      rx_ready_n_per_chan
);
   logic [2:0] pinSync;
   logic       forceEn;
   logic [NUM_CHAN-1:0] oeBit_reg;
   logic [NUM_CHAN-1:0] oeBit_next;
   qip_pin_grp_t        pins_reg;
   qip_pin_grp_t        pins_next;
   logic [NUM_CHAN-1:0] txRdyN_reg;
   logic [NUM_CHAN-1:0] txRdyN_next;
   logic [NUM_CHAN-1:0] rxRdyN_reg;
   logic [NUM_CHAN-1:0] rxRdyN_next;
   logic                csdSel_reg;
   logic                csdSel_next;

   // Force pin resets low to match its pull-down; select pin idles high
   qip_sync2 #(.WIDTH(3), .INIT(3'h6)) uSync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({busModeSel, chan_d_select_n, irq_force_enable}),
      .q     (pinSync)
   );

   assign strobeMode = (pinSync[2] == MODE_STROBE);  // see R1
   // Pull-down is external to logic; variant without the pin is tied high
   assign forceEn = HAS_FORCE_PIN ? pinSync[0] : 1'b1;  // see R11 see R13

   always_comb begin
      oeBit_next = oeBit_reg;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (oeBitWrite[i]) begin
            oeBit_next[i] = oeBitValue[i];
         end
      end
   end

   always_comb begin
      csdSel_next = strobeMode && !pinSync[1];  // see R2 see R3
      pins_next   = '0;
      if (strobeMode) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            pins_next.level[i] = chanIrq[i];
            pins_next.oe[i]    = forceEn | oeBit_next[i];  // see R4 see R5 see R6 see R9 see R10
         end
      end else begin
         // Open drain: pull low only while the device interrupt is pending
         pins_next.level[CHAN_A] = 1'b0;
         pins_next.oe[CHAN_A]    = |chanIrq;  // see R7
         for (int i = 1; i < NUM_CHAN; i++) begin
            pins_next.level[i] = 1'b0;
            pins_next.oe[i]    = 1'b1;  // see R8
         end
      end
   end

   always_comb begin
      txRdyN_next = fifoStat.txNotEmpty;  // see R14
      rxRdyN_next = ~fifoStat.rxHasData;  // see R15
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oeBit_reg  <= IRQ_OE_RESET;  // see R5
         pins_reg   <= '0;
         txRdyN_reg <= 4'hf;
         rxRdyN_reg <= 4'hf;
         csdSel_reg <= 1'b0;
      end else begin
         oeBit_reg  <= oeBit_next;
         pins_reg   <= pins_next;
         txRdyN_reg <= txRdyN_next;
         rxRdyN_reg <= rxRdyN_next;
         csdSel_reg <= csdSel_next;
      end
   end

   assign irq_output_enable_bit = oeBit_reg;
   assign irqPins               = pins_reg;
   assign chanDSelected         = csdSel_reg;
   assign tx_ready_n_per_chan   = txRdyN_reg;
   assign rx_ready_n_per_chan   = rxRdyN_reg;

   // Assertion helper: sync chain still shows reset values for two edges after release
   logic [1:0] warmCnt_reg;
   logic [1:0] warmCnt_next;

   always_comb begin
      warmCnt_next = (warmCnt_reg == 2'h3) ? warmCnt_reg : warmCnt_reg + 2'h1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         warmCnt_reg <= 2'h0;
      end else begin
         warmCnt_reg <= warmCnt_next;
      end
   end

   // Checks
   a_csd_ignored: assert property (@(posedge clk) disable iff (!rst_n)  // see R3
      !strobeMode |=> !chanDSelected)
      else $error("chan D selected in rw-line mode");
   a_csd_select: assert property (@(posedge clk) disable iff (!rst_n)  // see R2
      strobeMode && !pinSync[1] |=> chanDSelected)
      else $error("chan D select not honoured");
   a_oe_follow: assert property (@(posedge clk) disable iff (!rst_n)  // see R10
      strobeMode && !forceEn && !(|oeBitWrite) |=> irqPins.oe == oeBit_reg)
      else $error("irq enable does not follow enable bits");
   a_force_all: assert property (@(posedge clk) disable iff (!rst_n)  // see R9
      strobeMode && forceEn |=> irqPins.oe == 4'hf)
      else $error("force enable did not drive all outputs");
   a_chan_a_drive: assert property (@(posedge clk) disable iff (!rst_n)  // see R4
      strobeMode && oeBitWrite[0] && oeBitValue[0] |=> irqPins.oe[0])
      else $error("channel A not driven");
   a_chan_a_float: assert property (@(posedge clk) disable iff (!rst_n)  // see R5
      strobeMode && !forceEn && oeBitWrite[0] && !oeBitValue[0] |=> !irqPins.oe[0])
      else $error("channel A not floated");
   a_rw_od: assert property (@(posedge clk) disable iff (!rst_n)  // see R7
      !strobeMode |=> !irqPins.level[0] && irqPins.oe[0] == $past(|chanIrq))
      else $error("device irq not open drain");
   a_rw_low: assert property (@(posedge clk) disable iff (!rst_n)  // see R8
      !strobeMode |=> irqPins.level[3:1] == 3'h0 && irqPins.oe[3:1] == 3'h7)
      else $error("unused irq outputs not low");
   a_ready_pins: assert property (@(posedge clk) disable iff (!rst_n)  // see R14 see R15
      1'b1 |=> tx_ready_n_per_chan == $past(fifoStat.txNotEmpty)
            && rx_ready_n_per_chan == ~$past(fifoStat.rxHasData))
      else $error("ready pins wrong");

   // Channels B to D follow their own enable bits, writes included
   a_bd_follow: assert property (@(posedge clk) disable iff (!rst_n)  // see R6
      strobeMode && !forceEn |=> irqPins.oe[3:1] == oeBit_reg[3:1])
      else $error("B-D enables do not follow their bits");
   a_chan_b_drive: assert property (@(posedge clk) disable iff (!rst_n)  // see R6
      strobeMode && oeBitWrite[1] && oeBitValue[1] |=> irqPins.oe[1])
      else $error("channel B not driven");
   a_chan_b_float: assert property (@(posedge clk) disable iff (!rst_n)  // see R6
      strobeMode && !forceEn && oeBitWrite[1] && !oeBitValue[1] |=> !irqPins.oe[1])
      else $error("channel B not floated");
   a_chan_c_drive: assert property (@(posedge clk) disable iff (!rst_n)  // see R6
      strobeMode && oeBitWrite[2] && oeBitValue[2] |=> irqPins.oe[2])
      else $error("channel C not driven");
   a_chan_c_float: assert property (@(posedge clk) disable iff (!rst_n)  // see R6
      strobeMode && !forceEn && oeBitWrite[2] && !oeBitValue[2] |=> !irqPins.oe[2])
      else $error("channel C not floated");
   a_chan_d_drive: assert property (@(posedge clk) disable iff (!rst_n)  // see R6
      strobeMode && oeBitWrite[3] && oeBitValue[3] |=> irqPins.oe[3])
      else $error("channel D not driven");
   a_chan_d_float: assert property (@(posedge clk) disable iff (!rst_n)  // see R6
      strobeMode && !forceEn && oeBitWrite[3] && !oeBitValue[3] |=> !irqPins.oe[3])
      else $error("channel D not floated");
   a_strobe_level: assert property (@(posedge clk) disable iff (!rst_n)  // see R4 see R6
      strobeMode |=> irqPins.level == $past(chanIrq))
      else $error("strobe mode irq level wrong");

   // Reset state; no disable so the first released edge is seen
   a_reset_float: assert property (@(posedge clk)  // see R5
      $rose(rst_n) |-> irqPins.oe == 4'h0 && oeBit_reg == IRQ_OE_RESET)
      else $error("outputs not floating after reset");

   // Pin paths, once the sync chain holds real samples
   a_mode_track: assert property (@(posedge clk) disable iff (!rst_n)  // see R1
      warmCnt_reg == 2'h3 |-> strobeMode == ($past(busModeSel, 2) == MODE_STROBE))
      else $error("bus mode not decoded");
   a_csd_track: assert property (@(posedge clk) disable iff (!rst_n)  // see R2 see R3
      warmCnt_reg == 2'h3 |-> chanDSelected
         == ($past(busModeSel, 3) == MODE_STROBE && !$past(chan_d_select_n, 3)))
      else $error("chan D select does not track its pin");
   a_force_track: assert property (@(posedge clk) disable iff (!rst_n)  // see R11 see R13
      warmCnt_reg == 2'h3 |-> forceEn == (HAS_FORCE_PIN ? $past(irq_force_enable, 2) : 1'b1))
      else $error("force enable does not track its pin");

   c_strobe_irq: cover property (@(posedge clk) disable iff (!rst_n)
      strobeMode && irqPins.oe[0] && irqPins.level[0]);
   c_rw_irq: cover property (@(posedge clk) disable iff (!rst_n)
      !strobeMode && irqPins.oe[0]);
   c_force: cover property (@(posedge clk) disable iff (!rst_n)
      strobeMode && forceEn && oeBit_reg == 4'h0);
   c_chan_d_sel: cover property (@(posedge clk) disable iff (!rst_n)
      strobeMode && chanDSelected);
   c_float_a: cover property (@(posedge clk) disable iff (!rst_n)
      strobeMode && !forceEn && !irqPins.oe[0]);
endmodule

// *** core/qip_pkg.sv ***
// Shared constants and carrier types for the interrupt pin control block
package qip_pkg;
   localparam int NUM_CHAN = 4;
   localparam int CHAN_A = 0;
   localparam int CHAN_D = 3;
   // Reset value of each channel's interrupt output enable bit
   localparam logic [3:0] IRQ_OE_RESET = 4'h0;
   // Pin levels
   localparam logic MODE_STROBE = 1'b1;
   localparam logic MODE_RWLINE = 1'b0;

   typedef struct packed {
      logic [3:0] level;
      logic [3:0] oe;
   } qip_pin_grp_t;

   typedef struct packed {
      logic [3:0] txNotEmpty;
      logic [3:0] rxHasData;
   } qip_stat_t;
endpackage

// *** core/qip_sync2.sv ***
// Two-flip-flop synchroniser for a vector of pin inputs
module qip_sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= INIT;
         stage2_reg <= INIT;
      end else begin
         stage1_reg <= d;
         stage2_reg <= stage1_reg;
      end
   end

   assign q = stage2_reg;
endmodule

// *** verif/qip_irq_pin_ctrl_bench.sv ***
// Self-checking bench for the interrupt pin control block
module qip_irq_pin_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import qip_pkg::*;
   logic         clk = 0, rst_n = 0, busModeSel = 0, csdN = 1, forceReq = 0, irqForce;
   logic [3:0]   chanIrq = '0, oeBitWrite = '0, oeBitValue = '0, bits = '0;
   logic [3:0]   oeBits, pinWire, txN, rxN;
   logic         strobeMode, chanDSelected;
   qip_stat_t    fifoStat = '0;
   qip_pin_grp_t irqPins, irqPinsFixed, e;
   int           n_errors = 0, n_compared = 0, seed = 19916;
   always #2 clk = ~clk;
   qip_irq_pin_ctrl dut (.clk(clk), .rst_n(rst_n), .busModeSel(busModeSel),
      .chan_d_select_n(csdN), .irq_force_enable(irqForce), .chanIrq(chanIrq),
      .oeBitWrite(oeBitWrite), .oeBitValue(oeBitValue), .fifoStat(fifoStat),
      .irq_output_enable_bit(oeBits), .strobeMode(strobeMode),
      .chanDSelected(chanDSelected), .irqPins(irqPins),
      .tx_ready_n_per_chan(txN), .rx_ready_n_per_chan(rxN));
   qip_pin_env env (.busModeSel(busModeSel), .forceReq(forceReq), .irqPins(irqPins),
      .irq_force_enable(irqForce), .pinWire(pinWire));
   // Variant without the force pin
   qip_irq_pin_ctrl #(.HAS_FORCE_PIN(1'b0)) dutFixed (.clk(clk), .rst_n(rst_n),
      .busModeSel(busModeSel), .chan_d_select_n(csdN), .irq_force_enable(irqForce),
      .chanIrq(chanIrq), .oeBitWrite(oeBitWrite), .oeBitValue(oeBitValue),
      .fifoStat(fifoStat), .irq_output_enable_bit(), .strobeMode(), .chanDSelected(),
      .irqPins(irqPinsFixed), .tx_ready_n_per_chan(), .rx_ready_n_per_chan());
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function qip_pin_grp_t expPins(input logic m, f, input logic [3:0] b, q);
      // Rw-line: A requests only, levels low; B-D driven low
      expPins = m ? qip_pin_grp_t'({q, b | {4{f}}}) : qip_pin_grp_t'({4'h0, 3'h7, |q});
   endfunction
   task report_and_stop;
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(negedge clk);
      chk(irqPins, 16'h0000);
      chk({txN, rxN, oeBits}, 16'h0ff0);
      repeat (3) @(negedge clk);
      rst_n = 1;
      for (int p = 0; p < 40; p++) begin
         // Fixed mode walk first, then random pin settings
         busModeSel = p < 4 ? p[0] : 1'($random(seed));
         csdN = 1'($random(seed));
         forceReq = p < 4 ? p[1] : 1'($random(seed));
         repeat (4) @(negedge clk);
         chk(strobeMode, busModeSel);
         chk(chanDSelected, busModeSel & ~csdN);
         for (int c = 0; c < 16; c++) begin
            chanIrq = 4'($random(seed));
            oeBitWrite = c < 2 ? 4'hf : 4'($random(seed));
            oeBitValue = c == 0 ? 4'hf : c == 1 ? 4'h0 : 4'($random(seed));
            fifoStat = qip_stat_t'(8'($random(seed)));
            bits = (bits & ~oeBitWrite) | (oeBitWrite & oeBitValue);
            @(negedge clk);
            chk(oeBits, bits);
            e = expPins(busModeSel, irqForce, bits, chanIrq);
            chk(irqPins, e);
            chk(pinWire & e.oe, e.level & e.oe);
            chk(irqPinsFixed, expPins(busModeSel, 1'b1, bits, chanIrq));
            chk({txN, rxN}, {fifoStat.txNotEmpty, ~fifoStat.rxHasData});
            if (!busModeSel) chk(pinWire[0], ~|chanIrq);
         end
         oeBitWrite = '0;
      end
      report_and_stop();
   end
endmodule

// *** verif/qip_pin_env.sv ***
// Pin environment model: pulled-up shared wire and force-enable strap
module qip_pin_env
   import qip_pkg::*;
(
   // Pins
   input  wire logic         busModeSel,
   input  wire logic         forceReq,
   input  wire qip_pin_grp_t irqPins,
   output logic              irq_force_enable,
   output logic [3:0]        pinWire
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lastLevel = 4'h0;
   // System keeps force low in rw-line mode
   assign irq_force_enable = forceReq & busModeSel;
   // A has a pull-up; undriven lines B-D show the inverse of what they last carried
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++)
         pinWire[i] = irqPins.oe[i] ? irqPins.level[i] : (i == CHAN_A) | ~lastLevel[i];
   end
   always @(irqPins) begin
      for (int i = 0; i < NUM_CHAN; i++)
         if (irqPins.oe[i]) lastLevel[i] = irqPins.level[i];
   end
endmodule
